/* prm_cfg.svh */
// timing counts, field positions, control codes and reset values of the reduced MAC link
`ifndef PRM_CFG_SVH
`define PRM_CFG_SVH

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define PRM_MCLK_NS      25
`define PRM_HALF_NS_1000 4
`define PRM_HALF_NS_100  20
`define PRM_HALF_NS_10   200
// a half period needs room for a data change and a later clock edge
`define PRM_HALF_MIN     3
`define PRM_HALF_CYC(ns) (((ns) / `PRM_MCLK_NS > `PRM_HALF_MIN) ? (ns) / `PRM_MCLK_NS : `PRM_HALF_MIN)
`define PRM_PREFILL      2

// ---------------------------------------------------------------
// in-band status nibble fields
// ---------------------------------------------------------------
`define PRM_ST_LINK      0
`define PRM_ST_SPD_LO    1
`define PRM_ST_SPD_HI    2
`define PRM_ST_FDX       3

// ---------------------------------------------------------------
// control codes with enable or valid low and error high
// ---------------------------------------------------------------
`define PRM_C_LPI        8'h01
`define PRM_C_FCAR       8'h0e
`define PRM_C_CEXT       8'h0f
`define PRM_C_CERR       8'h1f
`define PRM_C_CSNS       8'hff

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define PRM_RST_CTL      1'b0
`define PRM_RST_NIB      4'h0
`define PRM_RST_ENT      10'h000

`endif

/* prm_pkg.sv */
// types shared by both ends of the reduced MAC link
package prm_pkg;

	typedef enum logic [1:0] {
		PRM_SPD_10   = 2'h0,
		PRM_SPD_100  = 2'h1,
		PRM_SPD_1000 = 2'h2,
		PRM_SPD_RSV  = 2'h3
	} prm_speed_t;

	typedef enum logic [2:0] {
		PRM_K_IDLE = 3'h0,
		PRM_K_DATA = 3'h1,
		PRM_K_ERRP = 3'h3,
		PRM_K_LPI  = 3'h2,
		PRM_K_CEXT = 3'h6,
		PRM_K_CERR = 3'h7,
		PRM_K_RSV  = 3'h5
	} prm_kind_t;

	typedef enum logic {
		PRM_H_RISE = 1'b0,
		PRM_H_FALL = 1'b1
	} prm_half_t;

endpackage

/* prm_if.sv */
// pin bundle between the mac end and the phy end
`timescale 1ns/1ps
interface prm_if;
	logic       txc;
	logic       tx_ctl;
	logic [3:0] txd;
	logic       rxc;
	logic       rx_ctl;
	logic [3:0] rxd;

	modport mac (output txc, tx_ctl, txd, input rxc, rx_ctl, rxd);
	modport phy (input txc, tx_ctl, txd, output rxc, rx_ctl, rxd);
endinterface

/* prm_mac.sv */
// mac end: ddr transmit sender and receive capture with in-band status
`timescale 1ns/1ps
`include "prm_cfg.svh"
module prm_mac
	import prm_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       rst,
	prm_if.mac              lnk,
	input  prm_speed_t      speed,
	input  wire logic [3:0] tx_delay,
	input  wire logic       tx_req,
	input  wire logic       tx_en,
	input  wire logic       tx_er,
	input  wire logic [7:0] tx_data,
	output logic            tx_take,
	output logic            rx_valid,
	output logic            rx_dv,
	output logic            rx_er,
	output logic [7:0]      rx_data,
	output logic            st_link,
	output prm_speed_t      st_speed,
	output logic            st_fdx
);

	// ---------------------------------------------------------------
	// transmit sender, mclk domain
	// ---------------------------------------------------------------
	logic [7:0] cnt_q;
	prm_half_t  half_q;
	logic       clk_q, hi_q, take_q, ctl_q;
	logic [3:0] d_q;
	logic [9:0] cur_q;
	wire  logic [7:0] hlen;
	wire  logic [7:0] dly;
	wire  logic [7:0] dl8;
	wire  logic       gig, fetch, take, use_hi, ctl_n;
	wire  logic [9:0] nxt;

	assign gig  = speed == PRM_SPD_1000;
	assign hlen = gig ? 8'(`PRM_HALF_CYC(`PRM_HALF_NS_1000)) :
	              (speed == PRM_SPD_100) ? 8'(`PRM_HALF_CYC(`PRM_HALF_NS_100)) :
	              8'(`PRM_HALF_CYC(`PRM_HALF_NS_10)); // [RULE6]
	assign dl8  = {4'h0, tx_delay};
	assign dly  = (dl8 == 8'h00) ? 8'h01 : (dl8 >= hlen) ? hlen - 8'h01 : dl8;
	assign fetch  = cnt_q == 8'h00 && half_q == PRM_H_RISE && !hi_q;
	assign take   = fetch && tx_req && !take_q;
	assign nxt    = fetch ? (take ? {tx_en, tx_er, tx_data} : `PRM_RST_ENT) : cur_q;
	// slow speeds repeat each rising-half nibble on the falling half to save toggling
	assign use_hi = gig ? (half_q == PRM_H_FALL) : hi_q; // [RULE7]
	assign ctl_n  = (half_q == PRM_H_RISE) ? nxt[9] : nxt[9] ^ nxt[8]; // [RULE9] [RULE11] [RULE8]

	always_ff @(posedge mclk) begin
		if (rst) begin
			cnt_q  <= 8'h00;
			half_q <= PRM_H_RISE;
			clk_q  <= 1'b0;
			hi_q   <= 1'b0;
			take_q <= 1'b0;
			cur_q  <= `PRM_RST_ENT;
			ctl_q  <= `PRM_RST_CTL;
			d_q    <= `PRM_RST_NIB;
		end else begin
			take_q <= take;
			if (cnt_q == 8'h00) begin
				cur_q <= nxt;
				ctl_q <= ctl_n;
				d_q   <= use_hi ? nxt[7:4] : nxt[3:0]; // [RULE5]
			end
			if (cnt_q == dly) begin
				clk_q <= (half_q == PRM_H_RISE); // [RULE4]
			end
			if (cnt_q >= hlen - 8'h01) begin
				cnt_q  <= 8'h00;
				half_q <= (half_q == PRM_H_RISE) ? PRM_H_FALL : PRM_H_RISE;
				if (half_q == PRM_H_FALL) begin
					hi_q <= gig ? 1'b0 : ~hi_q;
				end
			end else begin
				cnt_q <= cnt_q + 8'h01;
			end
		end
	end

	assign tx_take    = take_q;
	assign lnk.txc    = clk_q;
	assign lnk.tx_ctl = ctl_q;
	assign lnk.txd    = d_q;

	// ---------------------------------------------------------------
	// receive capture, rxc domain
	// ---------------------------------------------------------------
	logic [1:0] lrst_s, spd_s1, spd_s2, fst_q;
	logic       r_ctl_q, f_ctl_q, ph_q, tog_q, lreq_q;
	logic [3:0] r_d_q, f_d_q, lo_q;
	logic [9:0] wd_q;
	wire  logic en, er, lrst, lgig;

	assign lrst = lrst_s[1];
	assign lgig = spd_s2 == PRM_SPD_1000;
	assign en   = r_ctl_q;
	assign er   = r_ctl_q ^ f_ctl_q; // [RULE11]

	always_ff @(negedge lnk.rxc) begin
		f_ctl_q <= lnk.rx_ctl;
		f_d_q   <= lnk.rxd;
	end

	// rxc stands still during reset, so reset is raised at once and released on rxc
	always_ff @(posedge mclk) begin
		lreq_q <= rst;
	end

	always_ff @(posedge lnk.rxc or posedge lreq_q) begin
		if (lreq_q) begin
			lrst_s <= 2'h3;
		end else begin
			lrst_s <= {lrst_s[0], 1'b0};
		end
	end

	always_ff @(posedge lnk.rxc) begin
		spd_s1  <= speed;
		spd_s2  <= spd_s1;
		r_ctl_q <= lnk.rx_ctl;
		r_d_q   <= lnk.rxd;
	end

	always_ff @(posedge lnk.rxc or posedge lrst) begin
		if (lrst) begin
			ph_q  <= 1'b0;
			tog_q <= 1'b0;
			fst_q <= 2'h0;
			lo_q  <= `PRM_RST_NIB;
			wd_q  <= `PRM_RST_ENT;
		end else if (lgig) begin
			wd_q  <= {en, er, f_d_q, r_d_q}; // [RULE5]
			tog_q <= ~tog_q;
		end else if (en || ph_q) begin
			ph_q <= ~ph_q;
			if (!ph_q) begin
				lo_q  <= r_d_q;
				fst_q <= {en, er};
			end else begin
				wd_q  <= {fst_q[1], fst_q[0] | er, r_d_q, lo_q}; // [RULE7]
				tog_q <= ~tog_q;
			end
		end else begin
			wd_q  <= {en, er, r_d_q, r_d_q};
			tog_q <= ~tog_q;
		end
	end

	// ---------------------------------------------------------------
	// back into mclk: toggle synchroniser, word stable meanwhile
	// ---------------------------------------------------------------
	logic [2:0] tg_s;
	logic       ev_q;
	logic [9:0] tw_q;

	always_ff @(posedge mclk) begin
		if (rst) begin
			tg_s     <= 3'h0;
			ev_q     <= 1'b0;
			tw_q     <= `PRM_RST_ENT;
			rx_valid <= 1'b0;
			rx_dv    <= 1'b0;
			rx_er    <= 1'b0;
			rx_data  <= 8'h00;
			st_link  <= 1'b0;
			st_speed <= PRM_SPD_10;
			st_fdx   <= 1'b0;
		end else begin
			tg_s     <= {tg_s[1:0], tog_q};
			ev_q     <= tg_s[2] ^ tg_s[1];
			rx_valid <= ev_q;
			if (tg_s[2] ^ tg_s[1]) begin
				tw_q <= wd_q;
			end
			if (ev_q) begin
				rx_dv   <= tw_q[9];
				rx_er   <= tw_q[8];
				rx_data <= tw_q[7:0];
			end
			if (ev_q && !tw_q[9] && !tw_q[8]) begin
				st_link  <= tw_q[`PRM_ST_LINK]; // [RULE14]
				st_speed <= prm_speed_t'(tw_q[`PRM_ST_SPD_HI:`PRM_ST_SPD_LO]);
				st_fdx   <= tw_q[`PRM_ST_FDX];
			end
		end
	end

endmodule

/* prm_phy.sv */
// phy end: reduced gigabit and reduced 10/100 mac-side link logic
// Overview of operation
// RULE1: reduced 10/100 mode never runs or offers gigabit
// RULE2: reduced mode drives continuous free-running reference clock
// RULE3: phy holds elastic buffer for reduced mode
// RULE4: one clock, control, nibble bus per direction
// RULE5: sender changes lines on both clock edges
// RULE6: clock rate follows link speed; 1000 and 100 both get a 3-cycle half period here, 10 gets 8
// RULE7: slow speeds: replicated falling nibble is accepted
// RULE8: control keeps two distinct halves at slow speeds
// RULE9: mac sends enable, then enable xor error
// RULE10: phy sends valid, then valid xor error
// RULE11: enable rising half, coded error falling half
// RULE12: decode transmit control into frame kinds
// RULE13: only listed receive control codes are sent
// RULE14: inter-frame nibbles carry link, speed, duplex status
// RULE15: test loop speed: link speed or control bits
// RULE16: adjustable delay skews receive clock against data
// RULE17: idle receive: control low, status on data
`timescale 1ns/1ps
`include "prm_cfg.svh"
module prm_phy
	import prm_pkg::*;
#(
	parameter int DEPTH = 4,
	parameter int AW    = 2
)
(
	input  wire logic       mclk,
	input  wire logic       rst,
	prm_if.phy              lnk,
	input  wire logic       rmii_mode,
	input  wire logic       link_up,
	input  prm_speed_t      speed,
	input  wire logic       full_duplex,
	input  wire logic       loop_en,
	input  wire logic       sel_0_13,
	input  wire logic       sel_0_6,
	input  wire logic [3:0] rx_delay,
	input  wire logic       rx_req,
	input  wire logic       rx_dv_in,
	input  wire logic       rx_er_in,
	input  wire logic [7:0] rx_data_in,
	output logic            rx_take,
	output logic            gig_adv,
	output logic            tx_valid,
	output prm_kind_t       tx_kind,
	output logic [7:0]      tx_data
);

	// ---------------------------------------------------------------
	// speed selection
	// ---------------------------------------------------------------
	wire  prm_speed_t sel_spd;
	wire  prm_speed_t eff_spd;
	wire  logic [7:0] hlen, dly, dl8;
	wire  logic       gig;

	assign sel_spd = (loop_en && !link_up) ? prm_speed_t'({sel_0_6, sel_0_13}) : speed; // [RULE15]
	assign eff_spd = (rmii_mode && sel_spd == PRM_SPD_1000) ? PRM_SPD_100 : sel_spd; // [RULE1]
	assign gig     = eff_spd == PRM_SPD_1000;
	assign hlen    = gig ? 8'(`PRM_HALF_CYC(`PRM_HALF_NS_1000)) :
	                 (eff_spd == PRM_SPD_100) ? 8'(`PRM_HALF_CYC(`PRM_HALF_NS_100)) :
	                 8'(`PRM_HALF_CYC(`PRM_HALF_NS_10)); // [RULE6]
	// edge kept strictly inside the half so the mac never samples a change
	assign dl8     = {4'h0, rx_delay};
	assign dly     = (dl8 == 8'h00) ? 8'h01 : (dl8 >= hlen) ? hlen - 8'h01 : dl8; // [RULE16]

	// ---------------------------------------------------------------
	// receive entry buffer {valid, error, data}
	// ---------------------------------------------------------------
	logic [9:0]    mem [DEPTH];
	logic [AW-1:0] wp_q, rp_q;
	logic [AW:0]   cnt_q;
	logic          take_q;
	logic          lp_w;
	logic [9:0]    tw_q;
	logic [9:0]    cur_q;
	wire  logic    w_req, wr, full, pop, fetch, allow, code_ok;
	wire  logic [9:0] w_ent, head;

	assign full  = cnt_q == (AW+1)'(DEPTH);
	assign w_req = loop_en ? lp_w : (rx_req && !take_q);
	assign w_ent = loop_en ? tw_q : {rx_dv_in, rx_er_in, rx_data_in};
	assign wr    = w_req && !full;
	assign head  = mem[rp_q];
	// reduced mode waits for a prefill so a slow writer does not underrun mid frame
	assign allow = cnt_q != '0 && (!rmii_mode || cur_q[9] ||
	               cnt_q >= (AW+1)'(`PRM_PREFILL)); // [RULE3]
	assign pop   = fetch && allow;

	always_ff @(posedge mclk) begin
		if (wr) begin
			mem[wp_q] <= w_ent;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			wp_q   <= '0;
			rp_q   <= '0;
			cnt_q  <= '0;
			take_q <= 1'b0;
		end else begin
			wp_q   <= wp_q + AW'(wr);
			rp_q   <= rp_q + AW'(pop);
			cnt_q  <= cnt_q + (AW+1)'(wr) - (AW+1)'(pop);
			take_q <= wr && !loop_en;
		end
	end

	// ---------------------------------------------------------------
	// receive sender
	// ---------------------------------------------------------------
	logic [7:0] hc_q;
	prm_half_t  half_q;
	logic       clk_q, hi_q, ctl_q, gadv_q;
	logic [1:0] dib_q;
	logic [3:0] d_q;
	wire  logic [3:0] stat;
	wire  logic [9:0] idle_ent, pick, nxt;
	wire  logic [3:0] rm_d;
	wire  logic       use_hi, ctl_n;

	assign stat     = {full_duplex, eff_spd, link_up}; // [RULE14]
	assign idle_ent = {2'b00, stat, stat}; // [RULE17]
	assign code_ok  = head[7:0] == `PRM_C_LPI || head[7:0] == `PRM_C_FCAR ||
	                  head[7:0] == `PRM_C_CEXT || head[7:0] == `PRM_C_CERR ||
	                  head[7:0] == `PRM_C_CSNS;
	assign pick     = (pop && !(!head[9] && head[8] && !code_ok)) ? head : idle_ent; // [RULE13]
	assign fetch    = rmii_mode ? (clk_q && dib_q == 2'h0) :
	                  (hc_q == 8'h00 && half_q == PRM_H_RISE && !hi_q);
	assign nxt      = fetch ? pick : cur_q;
	assign use_hi   = gig ? (half_q == PRM_H_FALL) : hi_q; // [RULE7]
	assign ctl_n    = (half_q == PRM_H_RISE) ? nxt[9] : nxt[9] ^ nxt[8]; // [RULE10] [RULE11] [RULE8]
	assign rm_d     = {1'b0, nxt[8], 2'(nxt[7:0] >> {dib_q, 1'b0})};

	always_ff @(posedge mclk) begin
		if (rst) begin
			hc_q   <= 8'h00;
			half_q <= PRM_H_RISE;
			clk_q  <= 1'b0;
			hi_q   <= 1'b0;
			dib_q  <= 2'h0;
			cur_q  <= `PRM_RST_ENT;
			ctl_q  <= `PRM_RST_CTL;
			d_q    <= `PRM_RST_NIB;
			gadv_q <= 1'b0;
		end else if (rmii_mode) begin
			gadv_q <= 1'b0; // [RULE1]
			clk_q  <= ~clk_q; // [RULE2]
			hc_q   <= 8'h00;
			half_q <= PRM_H_RISE;
			hi_q   <= 1'b0;
			if (clk_q) begin
				cur_q <= nxt;
				ctl_q <= nxt[9];
				d_q   <= rm_d;
				dib_q <= nxt[9] ? dib_q + 2'h1 : 2'h0;
			end
		end else begin
			gadv_q <= 1'b1;
			dib_q  <= 2'h0;
			if (hc_q == 8'h00) begin
				cur_q <= nxt;
				ctl_q <= ctl_n;
				d_q   <= use_hi ? nxt[7:4] : nxt[3:0]; // [RULE5]
			end
			if (hc_q == dly) begin
				clk_q <= (half_q == PRM_H_RISE); // [RULE4]
			end
			if (hc_q >= hlen - 8'h01) begin
				hc_q   <= 8'h00;
				half_q <= (half_q == PRM_H_RISE) ? PRM_H_FALL : PRM_H_RISE;
				if (half_q == PRM_H_FALL) begin
					hi_q <= gig ? 1'b0 : ~hi_q;
				end
			end else begin
				hc_q <= hc_q + 8'h01;
			end
		end
	end

	assign rx_take    = take_q;
	assign gig_adv    = gadv_q;
	assign lnk.rxc    = clk_q;
	assign lnk.rx_ctl = ctl_q;
	assign lnk.rxd    = d_q;

	// ---------------------------------------------------------------
	// transmit capture, txc domain
	// ---------------------------------------------------------------
	logic [1:0] lrst_s, spd_s1, spd_s2, fst_q;
	logic       r_ctl_q, f_ctl_q, ph_q, tog_q, lreq_q;
	logic [3:0] r_d_q, f_d_q, lo_q;
	logic [9:0] wd_q;
	wire  logic en, er, lrst, lgig;

	assign lrst = lrst_s[1];
	assign lgig = spd_s2 == PRM_SPD_1000;
	assign en   = r_ctl_q;
	assign er   = r_ctl_q ^ f_ctl_q; // [RULE11]

	always_ff @(negedge lnk.txc) begin
		f_ctl_q <= lnk.tx_ctl;
		f_d_q   <= lnk.txd;
	end

	// txc stands still during reset, so reset is raised at once and released on txc
	always_ff @(posedge mclk) begin
		lreq_q <= rst;
	end

	always_ff @(posedge lnk.txc or posedge lreq_q) begin
		if (lreq_q) begin
			lrst_s <= 2'h3;
		end else begin
			lrst_s <= {lrst_s[0], 1'b0};
		end
	end

	always_ff @(posedge lnk.txc) begin
		spd_s1  <= eff_spd;
		spd_s2  <= spd_s1;
		r_ctl_q <= lnk.tx_ctl;
		r_d_q   <= lnk.txd;
	end

	always_ff @(posedge lnk.txc or posedge lrst) begin
		if (lrst) begin
			ph_q  <= 1'b0;
			tog_q <= 1'b0;
			fst_q <= 2'h0;
			lo_q  <= `PRM_RST_NIB;
			wd_q  <= `PRM_RST_ENT;
		end else if (lgig) begin
			wd_q  <= {en, er, f_d_q, r_d_q}; // [RULE5]
			tog_q <= ~tog_q;
		end else if (en || ph_q) begin
			ph_q <= ~ph_q;
			if (!ph_q) begin
				lo_q  <= r_d_q;
				fst_q <= {en, er};
			end else begin
				wd_q  <= {fst_q[1], fst_q[0] | er, r_d_q, lo_q}; // [RULE7]
				tog_q <= ~tog_q;
			end
		end else begin
			wd_q  <= {en, er, r_d_q, r_d_q};
			tog_q <= ~tog_q;
		end
	end

	// ---------------------------------------------------------------
	// transmit word into mclk and decode
	// ---------------------------------------------------------------
	logic [2:0] tg_s;
	logic       ev_q;
	wire  prm_kind_t kind;

	assign kind = (!tw_q[9] && !tw_q[8]) ? PRM_K_IDLE :
	              (tw_q[9] && !tw_q[8]) ? PRM_K_DATA :
	              tw_q[9] ? PRM_K_ERRP :
	              (tw_q[7:0] == `PRM_C_LPI) ? PRM_K_LPI :
	              (tw_q[7:0] == `PRM_C_CEXT) ? PRM_K_CEXT :
	              (tw_q[7:0] == `PRM_C_CERR) ? PRM_K_CERR : PRM_K_RSV; // [RULE12]

	always_ff @(posedge mclk) begin
		if (rst) begin
			tg_s     <= 3'h0;
			ev_q     <= 1'b0;
			tw_q     <= `PRM_RST_ENT;
			lp_w     <= 1'b0;
			tx_valid <= 1'b0;
			tx_kind  <= PRM_K_IDLE;
			tx_data  <= 8'h00;
		end else begin
			tg_s     <= {tg_s[1:0], tog_q};
			ev_q     <= tg_s[2] ^ tg_s[1];
			lp_w     <= 1'b0;
			tx_valid <= ev_q;
			if (tg_s[2] ^ tg_s[1]) begin
				tw_q <= wd_q;
			end
			if (ev_q) begin
				tx_kind <= kind;
				tx_data <= tw_q[7:0];
				lp_w    <= kind != PRM_K_IDLE; // [RULE15]
			end
		end
	end

endmodule

/* prm_link_checker.sv */
// assertions on the pins between the mac end and the phy end
`timescale 1ns/1ps
module prm_link_checker #(
	parameter int DLY = 2
)
(
	input wire logic       mclk,
	input wire logic       rst,
	input wire logic       txc,
	input wire logic       tx_ctl,
	input wire logic [3:0] txd,
	input wire logic       rxc,
	input wire logic       rx_ctl,
	input wire logic [3:0] rxd
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	// ---------------------------------------------------------------
	// rising-half copy of the receive lines
	// ---------------------------------------------------------------
	logic       rc_q;
	logic [3:0] rn_q;

	always_ff @(posedge mclk) begin
		if (rst) begin
			rc_q <= 1'b0;
			rn_q <= 4'h0;
		end else if ($rose(rxc)) begin
			rc_q <= rx_ctl;
			rn_q <= rxd;
		end
	end

	// ---------------------------------------------------------------
	// properties
	// ---------------------------------------------------------------
	// lines lead the clock edge by the delay, so no sample lands on a change
	a_rxd_lead: assert property ($changed(rxd) |-> ##DLY $changed(rxc))
		else $error("rxd change without rxc edge after delay");
	a_txd_lead: assert property ($changed(txd) |-> ##DLY $changed(txc))
		else $error("txd change without txc edge after delay");
	a_rxctl_lead: assert property ($changed(rx_ctl) |-> ##DLY $changed(rxc))
		else $error("rx_ctl change without rxc edge after delay");
	a_txctl_lead: assert property ($changed(tx_ctl) |-> ##DLY $changed(txc))
		else $error("tx_ctl change without txc edge after delay");
	a_rxc_half: assert property ($changed(rxc) |=> (!$changed(rxc))[*2] ##[1:6] $changed(rxc))
		else $error("rxc half period out of range");
	a_txc_half: assert property ($changed(txc) |=> (!$changed(txc))[*2] ##[1:6] $changed(txc))
		else $error("txc half period out of range");
	a_idle_status: assert property ($fell(rxc) && !rc_q && !rx_ctl |-> rxd == rn_q)
		else $error("idle status nibble differs between halves");
	a_rx_code_set: assert property ($fell(rxc) && !rc_q && rx_ctl |-> rn_q inside {4'h0, 4'h1, 4'he, 4'hf})
		else $error("receive code word outside the listed set");
endmodule

/* phy_reduced_mac_interface_test.sv */
// self-checking bench for both ends of the reduced mac link
`timescale 1ns/1ps
module phy_reduced_mac_interface_test
	import prm_pkg::*;
;
	// ---------------------------------------------------------------
	// signals and tables
	// ---------------------------------------------------------------
	logic        mclk, rst, link_up, full_duplex, loop_en, sel_0_13, sel_0_6;
	logic        rx_req, rx_req_b, tx_req, rx_dv_in, rx_er_in, tx_en, tx_er;
	logic [7:0]  rx_data_in, tx_data_i, tx_data, rx_data;
	logic [3:0]  dly;
	prm_speed_t  speed, mspeed, st_speed;
	prm_kind_t   tx_kind;
	logic        rx_take, rx_take_b, gig_adv, gig_adv_b, tx_valid, tx_take;
	logic        rx_valid, rx_dv, rx_er, st_link, st_fdx, rxc_p, p;
	logic [2:0]  tk;
	int          bad_count, comparisons, n;
	logic [9:0]  rq[$];
	logic [10:0] tq[$];
	logic [1:0]  bq[$];
	prm_speed_t  spd[3] = '{PRM_SPD_1000, PRM_SPD_100, PRM_SPD_10};
	logic [9:0]  rx_tab[8] = '{10'h2a5, 10'h33c, 10'h101, 10'h102, 10'h10e, 10'h10f, 10'h11f, 10'h1ff};
	logic [12:0] tx_tab[6] = '{{2'b10, 8'h5a, PRM_K_DATA}, {2'b11, 8'hc3, PRM_K_ERRP},
		{2'b01, 8'h01, PRM_K_LPI}, {2'b01, 8'h0f, PRM_K_CEXT}, {2'b01, 8'h1f, PRM_K_CERR},
		{2'b01, 8'h02, PRM_K_RSV}};
	// {link_up, phy speed, sel_0_6 sel_0_13, mac speed}
	logic [6:0]  lp_tab[3] = '{7'h20, 7'h51, 7'h05};

	assign tk = {tx_take, rx_take_b, rx_take};

	// ---------------------------------------------------------------
	// both ends, a second phy end in reduced 10/100 mode
	// ---------------------------------------------------------------
	prm_if u_prm_if ();
	prm_if u_prm_if_b ();
	assign u_prm_if_b.txc = u_prm_if.txc;
	assign u_prm_if_b.tx_ctl = u_prm_if.tx_ctl;
	assign u_prm_if_b.txd = u_prm_if.txd;

	prm_mac u_prm_mac (.mclk(mclk), .rst(rst), .lnk(u_prm_if), .speed(mspeed), .tx_delay(dly),
		.tx_req(tx_req), .tx_en(tx_en), .tx_er(tx_er), .tx_data(tx_data_i), .tx_take(tx_take),
		.rx_valid(rx_valid), .rx_dv(rx_dv), .rx_er(rx_er), .rx_data(rx_data),
		.st_link(st_link), .st_speed(st_speed), .st_fdx(st_fdx));
	prm_phy u_prm_phy (.mclk(mclk), .rst(rst), .lnk(u_prm_if), .rmii_mode(1'b0),
		.link_up(link_up), .speed(speed), .full_duplex(full_duplex), .loop_en(loop_en),
		.sel_0_13(sel_0_13), .sel_0_6(sel_0_6), .rx_delay(dly), .rx_req(rx_req),
		.rx_dv_in(rx_dv_in), .rx_er_in(rx_er_in), .rx_data_in(rx_data_in), .rx_take(rx_take),
		.gig_adv(gig_adv), .tx_valid(tx_valid), .tx_kind(tx_kind), .tx_data(tx_data));
	prm_phy u_prm_phy_b (.mclk(mclk), .rst(rst), .lnk(u_prm_if_b), .rmii_mode(1'b1),
		.link_up(link_up), .speed(speed), .full_duplex(full_duplex), .loop_en(loop_en),
		.sel_0_13(sel_0_13), .sel_0_6(sel_0_6), .rx_delay(dly), .rx_req(rx_req_b),
		.rx_dv_in(rx_dv_in), .rx_er_in(rx_er_in), .rx_data_in(rx_data_in),
		.rx_take(rx_take_b), .gig_adv(gig_adv_b), .tx_valid(), .tx_kind(), .tx_data());
	prm_link_checker #(.DLY(2)) u_prm_link_checker (.mclk(mclk), .rst(rst),
		.txc(u_prm_if.txc), .tx_ctl(u_prm_if.tx_ctl), .txd(u_prm_if.txd),
		.rxc(u_prm_if.rxc), .rx_ctl(u_prm_if.rx_ctl), .rxd(u_prm_if.rxd));

	// ---------------------------------------------------------------
	// clock, monitors, tasks
	// ---------------------------------------------------------------
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	// idle words are dropped here so queues hold only frame and code words
	always @(posedge mclk) begin
		#2;
		if (rx_valid === 1'b1 && (rx_dv | rx_er) === 1'b1)
			rq.push_back({rx_dv, rx_er, rx_data});
		if (tx_valid === 1'b1 && tx_kind !== PRM_K_IDLE)
			tq.push_back({tx_kind, tx_data});
		if (u_prm_if_b.rxc === 1'b1 && rxc_p === 1'b0 && u_prm_if_b.rx_ctl === 1'b1)
			bq.push_back(u_prm_if_b.rxd[1:0]);
		rxc_p = u_prm_if_b.rxc;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic step(input int c);
		repeat (c) @(posedge mclk);
		#1;
	endtask

	// w: 0 phy receive entry, 1 reduced phy entry, 2 mac transmit byte
	task automatic send(input int w, input logic a, input logic e, input logic [7:0] d);
		int k;
		@(posedge mclk);
		#1;
		{rx_dv_in, rx_er_in, rx_data_in} = {a, e, d};
		{tx_en, tx_er, tx_data_i} = {a, e, d};
		rx_req = (w == 0);
		rx_req_b = (w == 1);
		tx_req = (w == 2);
		k = 0;
		do begin
			@(posedge mclk);
			#1;
			k++;
		end while (tk[w] !== 1'b1 && k < 400);
		{rx_req, rx_req_b, tx_req} = 3'h0;
		check(16'(k == 400), 16'h0);
	endtask

	task automatic final_report();
		$display("mismatches %0d, comparisons %0d", bad_count, comparisons);
		if (bad_count == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial begin
		#500000;
		bad_count++;
		final_report();
	end

	// ---------------------------------------------------------------
	// tests
	// ---------------------------------------------------------------
	initial begin
		rst = 1'b1;
		{link_up, full_duplex, loop_en, sel_0_13, sel_0_6} = 5'h00;
		{rx_req, rx_req_b, tx_req, rx_dv_in, rx_er_in, tx_en, tx_er} = 7'h00;
		{rx_data_in, tx_data_i} = 16'h0000;
		speed = PRM_SPD_10;
		mspeed = PRM_SPD_10;
		dly = 4'h2;
		bad_count = 0;
		comparisons = 0;
		step(12);
		rst = 1'b0;
		foreach (spd[i]) begin
			speed = spd[i];
			mspeed = spd[i];
			link_up = 1'b1;
			full_duplex = (i != 2);
			step(80);
			check(st_link, 1'b1);
			check(st_speed, spd[i]);
			check(st_fdx, i != 2);
			check(gig_adv, 1'b1);
			rq.delete();
			tq.delete();
			// code words need frame alignment, which only full rate gives without a frame
			n = (i == 0) ? 8 : 2;
			for (int k = 0; k < n; k++)
				send(0, rx_tab[k][9], rx_tab[k][8], rx_tab[k][7:0]);
			step(300);
			check(16'(rq.size()), 16'((i == 0) ? 7 : 2));
			for (int k = 0; k < n; k++)
				if (k != 3) check(rq.pop_front(), rx_tab[k]);
			n = (i == 0) ? 6 : 2;
			for (int k = 0; k < n; k++)
				send(2, tx_tab[k][12], tx_tab[k][11], tx_tab[k][10:3]);
			step(300);
			check(16'(tq.size()), 16'(n));
			for (int k = 0; k < n; k++)
				check(tq.pop_front(), {tx_tab[k][2:0], tx_tab[k][10:3]});
		end
		link_up = 1'b0;
		step(80);
		check(st_link, 1'b0);
		loop_en = 1'b1;
		foreach (lp_tab[k]) begin
			link_up = lp_tab[k][6];
			speed = prm_speed_t'(lp_tab[k][5:4]);
			{sel_0_6, sel_0_13} = lp_tab[k][3:2];
			mspeed = prm_speed_t'(lp_tab[k][1:0]);
			step(80);
			rq.delete();
			send(2, 1'b1, 1'b0, 8'h96 ^ 8'(k));
			step(300);
			check(16'(rq.size()), 16'h1);
			check(rq.pop_front(), {2'b10, 8'h96 ^ 8'(k)});
		end
		loop_en = 1'b0;
		link_up = 1'b1;
		speed = PRM_SPD_100;
		step(40);
		check(gig_adv_b, 1'b0);
		n = 0;
		p = u_prm_if_b.rxc;
		for (int k = 0; k < 40; k++) begin
			step(1);
			n += int'(u_prm_if_b.rxc !== p);
			p = u_prm_if_b.rxc;
		end
		check(16'(n), 16'd40);
		// the reduced end looped the last word too, which still waits for a prefill partner
		bq.delete();
		send(1, 1'b1, 1'b0, 8'h5c);
		step(100);
		check(16'(bq.size()), 16'd8);
		check({bq[7], bq[6], bq[5], bq[4], bq[3], bq[2], bq[1], bq[0]}, 16'h5c94);
		bq.delete();
		send(1, 1'b1, 1'b0, 8'hb4);
		send(1, 1'b1, 1'b0, 8'h4b);
		step(100);
		check(16'(bq.size()), 16'd8);
		check({bq[7], bq[6], bq[5], bq[4], bq[3], bq[2], bq[1], bq[0]}, 16'h4bb4);
		final_report();
	end
endmodule
